// ### qdma_fifo.sv
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module qdma_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count    <= next_count;
      in_ready <= (next_count < (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

// ### qdma_master.sv
// constants package and backplane interrupt / dma master for a disc controller
`timescale 1ns/1ps
`default_nettype none
package qdma_pkg;
  localparam int DAL_W         = 22;
  localparam int DATA_W        = 16;
  localparam int CNT_W         = 16;
  localparam int LVL_N         = 4;
  localparam int FIFO_DEPTH    = 8;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PAUSE_NS      = 4000;
  localparam int PAUSE_CYC     = (PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_MAX     = 16;
  localparam int THROTTLE_MAX  = 8;
  localparam logic [4:0] BURST_W5    = 5'h10;
  localparam logic [4:0] THROTTLE_W5 = 5'h08;
  localparam logic [4:0] SINGLE_W5   = 5'h01;
  localparam logic [6:0] PAUSE_C7    = 7'(PAUSE_CYC);
  localparam logic [DAL_W-1:0] ADDR_STEP = 22'h000002;
  localparam logic [15:0] VECTOR_DEFAULT = 16'h0154;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_REQ   = 4'h1,
    ST_ADDR  = 4'h2,
    ST_SYNC  = 4'h3,
    ST_DATA  = 4'h4,
    ST_RPLY  = 4'h5,
    ST_NRPLY = 4'h6,
    ST_END   = 4'h7,
    ST_PAUSE = 4'h8
  } qdma_dma_st_t;

  typedef enum logic [1:0] {
    IS_IDLE = 2'h0,
    IS_REQ  = 2'h1,
    IS_VEC  = 2'h2,
    IS_DONE = 2'h3
  } qdma_int_st_t;
endpackage

module qdma_master #(
  parameter logic [15:0] VECTOR = qdma_pkg::VECTOR_DEFAULT
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire logic [1:0]                 irq_level_sel,
  input  wire logic                       int_enable,
  input  wire logic                       int_event,
  output logic      [qdma_pkg::LVL_N-1:0] irq_out,
  input  wire logic                       iak_in,
  output logic                            iak_out,
  input  wire logic                       din_in,
  input  wire logic                       sync_in,
  input  wire logic                       rply_in,
  output logic                            rply_out,
  output logic                            sync_out,
  output logic                            din_out,
  output logic                            dout_out,
  output logic                            dmr_out,
  input  wire logic                       dmg_in,
  output logic                            dmg_out,
  output logic                            sack_out,
  input  wire logic                       other_dmr_in,
  input  wire logic [qdma_pkg::DAL_W-1:0] dal_in,
  output logic      [qdma_pkg::DAL_W-1:0] dal_out,
  output logic                            dal_oe,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire logic [qdma_pkg::DAL_W-1:0] cmd_addr,
  input  wire logic [qdma_pkg::CNT_W-1:0] cmd_words,
  input  wire logic                       cmd_to_mem,
  input  wire logic                       cmd_block,
  input  wire logic                       abort,
  input  wire logic                       wr_valid,
  output logic                            wr_ready,
  input  wire logic [qdma_pkg::DATA_W-1:0] wr_data,
  output logic                            rd_valid,
  output logic      [qdma_pkg::DATA_W-1:0] rd_data,
  output logic                            done,
  output logic                            busy
);
  qdma_pkg::qdma_dma_st_t   st;
  qdma_pkg::qdma_int_st_t   ist;
  logic [1:0]               level;
  logic                     pending;
  logic [qdma_pkg::DAL_W-1:0] addr;
  logic [qdma_pkg::CNT_W-1:0] remaining;
  logic [4:0]               burst_cnt;
  logic [4:0]               limit;
  logic [6:0]               pause_cnt;
  logic                     throttle;
  logic                     to_mem;
  logic                     block;
  logic                     aborted;
  logic                     f_valid;
  logic                     f_ready;
  logic [qdma_pkg::DATA_W-1:0] f_data;
  logic                     vec_take;

  qdma_fifo #(
    .WIDTH (qdma_pkg::DATA_W),
    .DEPTH (qdma_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .reset     (reset),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  assign f_ready  = (st == qdma_pkg::ST_DATA) && to_mem;
  assign vec_take = (ist == qdma_pkg::IS_REQ) && iak_in && din_in && (irq_out != '0);
  assign limit    = !block ? qdma_pkg::SINGLE_W5 :
                    throttle ? qdma_pkg::THROTTLE_W5 : qdma_pkg::BURST_W5;

  // ----------------------------------------------------------------
  // interrupt request and vector
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level <= irq_level_sel;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pending <= 1'b0;
    end else if (int_event && int_enable) begin
      pending <= 1'b1;
    end else if (ist == qdma_pkg::IS_VEC && !din_in) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ist <= qdma_pkg::IS_IDLE;
    end else begin
      case (ist)
        qdma_pkg::IS_IDLE: begin
          if (pending && int_enable) begin
            ist <= qdma_pkg::IS_REQ;
          end
        end
        qdma_pkg::IS_REQ: begin
          if (vec_take) begin
            ist <= qdma_pkg::IS_VEC;
          end else if (!int_enable) begin
            ist <= qdma_pkg::IS_IDLE;
          end
        end
        qdma_pkg::IS_VEC: begin
          if (!din_in) begin
            ist <= qdma_pkg::IS_DONE;
          end
        end
        qdma_pkg::IS_DONE: begin
          if (!iak_in) begin
            ist <= qdma_pkg::IS_IDLE;
          end
        end
        default: ist <= qdma_pkg::IS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_out  <= '0;
      iak_out  <= 1'b0;
      rply_out <= 1'b0;
    end else begin
      irq_out  <= '0;
      if (ist == qdma_pkg::IS_REQ && int_enable && !vec_take) begin
        irq_out[level] <= 1'b1;
      end
      // acknowledge passes down the chain only when not claimed here
      iak_out  <= iak_in && (ist == qdma_pkg::IS_IDLE) && !(pending && int_enable);
      rply_out <= vec_take || (ist == qdma_pkg::IS_VEC && din_in);
    end
  end

  // ----------------------------------------------------------------
  // dma sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st        <= qdma_pkg::ST_IDLE;
      addr      <= '0;
      remaining <= '0;
      burst_cnt <= '0;
      pause_cnt <= '0;
      throttle  <= 1'b0;
      to_mem    <= 1'b0;
      block     <= 1'b0;
      aborted   <= 1'b0;
    end else begin
      if (abort && st != qdma_pkg::ST_IDLE) begin
        aborted <= 1'b1;
      end
      case (st)
        qdma_pkg::ST_IDLE: begin
          aborted <= 1'b0;
          if (cmd_valid && cmd_ready) begin
            addr      <= cmd_addr;
            remaining <= cmd_words;
            to_mem    <= cmd_to_mem;
            block     <= cmd_block;
            st        <= (cmd_words == '0) ? qdma_pkg::ST_END : qdma_pkg::ST_REQ;
          end
        end
        qdma_pkg::ST_REQ: begin
          if (abort || aborted) begin
            st <= qdma_pkg::ST_END;
          end else if (dmg_in && !sync_in && !rply_in) begin
            st <= qdma_pkg::ST_ADDR;
          end
        end
        qdma_pkg::ST_ADDR: begin
          burst_cnt <= '0;
          throttle  <= other_dmr_in;
          st        <= qdma_pkg::ST_SYNC;
        end
        qdma_pkg::ST_SYNC: begin
          st <= qdma_pkg::ST_DATA;
        end
        qdma_pkg::ST_DATA: begin
          if (abort || aborted) begin
            st <= qdma_pkg::ST_END;
          end else if (!to_mem || f_valid) begin
            st <= qdma_pkg::ST_RPLY;
          end
        end
        qdma_pkg::ST_RPLY: begin
          throttle <= throttle || other_dmr_in;
          if (abort) begin
            st <= qdma_pkg::ST_END;
          end else if (rply_in) begin
            addr      <= addr + qdma_pkg::ADDR_STEP;
            remaining <= remaining - 1'b1;
            burst_cnt <= burst_cnt + 1'b1;
            st        <= qdma_pkg::ST_NRPLY;
          end
        end
        qdma_pkg::ST_NRPLY: begin
          if (!rply_in) begin
            if (remaining == '0 || burst_cnt >= limit || aborted) begin
              st <= qdma_pkg::ST_END;
            end else begin
              st <= qdma_pkg::ST_DATA;
            end
          end
        end
        qdma_pkg::ST_END: begin
          if (remaining == '0 || aborted) begin
            st <= qdma_pkg::ST_IDLE;
          end else if (block && burst_cnt == qdma_pkg::BURST_W5) begin
            pause_cnt <= qdma_pkg::PAUSE_C7 - 1'b1;
            st        <= qdma_pkg::ST_PAUSE;
          end else begin
            st <= qdma_pkg::ST_REQ;
          end
        end
        qdma_pkg::ST_PAUSE: begin
          if (abort) begin
            st <= qdma_pkg::ST_END;
          end else if (pause_cnt == '0) begin
            st <= qdma_pkg::ST_REQ;
          end else begin
            pause_cnt <= pause_cnt - 1'b1;
          end
        end
        default: st <= qdma_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dmr_out   <= 1'b0;
      dmg_out   <= 1'b0;
      sack_out  <= 1'b0;
      sync_out  <= 1'b0;
      din_out   <= 1'b0;
      dout_out  <= 1'b0;
      cmd_ready <= 1'b0;
      busy      <= 1'b0;
      done      <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
    end else begin
      dmr_out   <= (st == qdma_pkg::ST_REQ) && !(dmg_in && !sync_in && !rply_in);
      dmg_out   <= dmg_in && (st != qdma_pkg::ST_REQ) && !sack_out;
      if (st == qdma_pkg::ST_REQ && dmg_in && !sync_in && !rply_in && !abort && !aborted) begin
        sack_out <= 1'b1;
      end else if (st == qdma_pkg::ST_END) begin
        sack_out <= 1'b0;
      end
      sync_out  <= (st == qdma_pkg::ST_SYNC) || (sync_out && st != qdma_pkg::ST_END);
      din_out   <= (st == qdma_pkg::ST_DATA && !to_mem && !abort && !aborted) ||
                   (din_out && st == qdma_pkg::ST_RPLY && !rply_in && !abort);
      dout_out  <= (st == qdma_pkg::ST_DATA && to_mem && f_valid && !abort && !aborted) ||
                   (dout_out && st == qdma_pkg::ST_RPLY && !rply_in && !abort);
      cmd_ready <= (st == qdma_pkg::ST_IDLE) && !(cmd_valid && cmd_ready);
      busy      <= (st != qdma_pkg::ST_IDLE) || (cmd_valid && cmd_ready);
      done      <= (st == qdma_pkg::ST_END) && (remaining == '0 || aborted);
      rd_valid  <= (st == qdma_pkg::ST_RPLY) && rply_in && !to_mem && !abort;
      if (st == qdma_pkg::ST_RPLY && rply_in && !to_mem) begin
        rd_data <= dal_in[qdma_pkg::DATA_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // shared address / data lines
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dal_out <= '0;
      dal_oe  <= 1'b0;
    end else if (vec_take) begin
      dal_out <= {6'h00, VECTOR};
      dal_oe  <= 1'b1;
    end else if (ist == qdma_pkg::IS_VEC) begin
      dal_oe  <= din_in;
    end else if (st == qdma_pkg::ST_ADDR) begin
      dal_out <= addr;
      dal_oe  <= 1'b1;
    end else if (st == qdma_pkg::ST_DATA) begin
      dal_out <= {6'h00, f_data};
      dal_oe  <= to_mem && f_valid;
    end else if (st == qdma_pkg::ST_END || st == qdma_pkg::ST_IDLE) begin
      dal_oe  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_IRQ_ENABLE: assert property ((irq_out != '0) |-> $past(int_enable))
    else $error("interrupt request without enable");
  AST_IRQ_LEVEL: assert property ((irq_out != '0) |-> (irq_out == (4'h1 << level)))
    else $error("interrupt request on wrong level");
  AST_VECTOR: assert property ($rose(rply_out) && !sack_out
    |-> dal_oe && dal_out[15:0] == VECTOR)
    else $error("vector not driven with reply");
  AST_DROP: assert property ((ist == qdma_pkg::IS_VEC) |=> (irq_out == '0))
    else $error("request held after vector");
  AST_BUS_FREE: assert property ($rose(sack_out) |-> $past(!sync_in && !rply_in && dmg_in))
    else $error("mastership taken on busy bus or without grant");
  AST_BURST_CAP: assert property ((st == qdma_pkg::ST_DATA) |-> (burst_cnt < limit))
    else $error("burst exceeds its word limit");
  AST_ONE_ADDR: assert property ((st == qdma_pkg::ST_ADDR) |=> dal_oe && dal_out == $past(addr)
    ##1 sync_out)
    else $error("address cycle malformed");
  AST_PAUSE: assert property ($rose(st == qdma_pkg::ST_PAUSE)
    |-> pause_cnt == qdma_pkg::PAUSE_C7 - 1'b1 && !sack_out && !dmr_out)
    else $error("block pause wrong length or bus held");
  AST_RELEASE: assert property ((st == qdma_pkg::ST_END) |=> !sack_out && !sync_out)
    else $error("mastership not released");
  AST_SINGLE: assert property ((st == qdma_pkg::ST_NRPLY && !block) |-> burst_cnt == 5'h01)
    else $error("single transfer moved more than one word");
  AST_GRANT_KEPT: assert property (sack_out |-> !dmg_out)
    else $error("grant passed on while holding the bus");
  AST_CHAIN_HELD: assert property ((irq_out != '0) |=> !iak_out)
    else $error("acknowledge passed on while requesting");

  COV_VECTOR: cover property (vec_take ##[1:20] ist == qdma_pkg::IS_DONE);
  COV_PAUSE: cover property (st == qdma_pkg::ST_PAUSE && pause_cnt == '0);
  COV_THROTTLE: cover property (st == qdma_pkg::ST_END && throttle && burst_cnt == 5'h08);
  COV_ABORT: cover property (done && aborted);
endmodule
`default_nettype wire

// ### qdma_host_model.sv
// processor and bus arbiter model facing the dma / interrupt master
`timescale 1ns/1ps
`default_nettype none
module qdma_host_model (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [1:0]  delay,
  input  wire logic [3:0]  irq_out,
  input  wire logic        rply_out,
  input  wire logic        dmr_out,
  input  wire logic        sack_out,
  input  wire logic        sync_out,
  input  wire logic        din_out,
  input  wire logic        dout_out,
  input  wire logic [21:0] dal_out,
  output logic             dmg_in,
  output logic             sync_in,
  output logic             rply_in,
  output logic             iak_in,
  output logic             din_in,
  output logic      [21:0] dal_in,
  output logic      [21:0] addr,
  output logic      [15:0] addr_cnt,
  output logic             mem_wr,
  output logic             vec_take,
  output logic      [15:0] seen
);
  logic       sync_q;
  logic [1:0] wait_c;
  logic [1:0] ist;
  always_ff @(posedge ref_clk) begin
    mem_wr <= 1'b0;
    vec_take <= 1'b0;
    sync_q <= sync_out;
    if (reset) begin
      {dmg_in, sync_in, rply_in, iak_in, din_in, ist, wait_c} <= '0;
      addr_cnt <= 16'h0000;
      dal_in <= 22'h2AAAAA;
    end else begin
      // grant at a random moment, never while a vector is pending
      dmg_in <= dmr_out & ~sack_out & ~din_in & (delay != 2'h0);
      // earlier master may still be finishing its cycle when the grant arrives
      sync_in <= dmr_out & ~sack_out & ~dmg_in & (delay == 2'h3);
      if (sync_out & ~sync_q) begin
        addr <= dal_out;
        addr_cnt <= addr_cnt + 16'h0001;
      end
      if ((din_out | dout_out) & ~rply_in) begin
        if (wait_c >= delay) begin
          rply_in <= 1'b1;
          wait_c <= 2'h0;
          if (din_out) begin
            dal_in <= {6'h00, 16'h5A5A ^ addr[15:0] ^ {addr[21:16], 10'h000}};
          end else begin
            seen <= dal_out[15:0];
            mem_wr <= 1'b1;
          end
        end else begin
          wait_c <= wait_c + 2'h1;
        end
      end else if (rply_in & ~din_out & ~dout_out) begin
        rply_in <= 1'b0;
        addr <= addr + 22'h000002;
      end else if (!rply_in) begin
        // released lines do not hold their last value
        dal_in <= ~dal_in;
      end
      case (ist)
        2'h0: if ((irq_out != 4'h0) & ~sack_out & ~dmr_out) begin
          din_in <= 1'b1;
          ist <= 2'h1;
        end
        2'h1: begin
          iak_in <= 1'b1;
          ist <= 2'h2;
        end
        2'h2: if (rply_out) begin
          seen <= dal_out[15:0];
          vec_take <= 1'b1;
          din_in <= 1'b0;
          ist <= 2'h3;
        end
        default: if (!rply_out) begin
          iak_in <= 1'b0;
          ist <= 2'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### qdma_master_test.sv
// self-checking testbench for the backplane dma and interrupt master
`timescale 1ns/1ps
`default_nettype none
module qdma_master_test;
  logic        ref_clk = 1'b0, reset = 1'b1, int_enable = 1'b0, int_event = 1'b0;
  logic [1:0]  irq_level_sel = 2'h0;
  logic        other_dmr_in = 1'b0, abort = 1'b0, cmd_valid = 1'b0, cmd_to_mem = 1'b0;
  logic        cmd_block = 1'b0, wr_valid = 1'b0;
  logic [21:0] cmd_addr = 22'h000000, waddr = 22'h000000;
  logic [15:0] cmd_words = 16'h0000, wr_data = 16'h0000;
  logic [3:0]  irq_out;
  logic        iak_in, iak_out, din_in, rply_in, rply_out, sync_out, din_out, dout_out;
  logic        dmr_out, dmg_in, dmg_out, sack_out, dal_oe, cmd_ready, wr_ready;
  logic        rd_valid, done, busy, mem_wr, vec_take, sync_in;
  logic [21:0] dal_in, dal_out, addr;
  logic [15:0] rd_data, addr_cnt, seen, gap = 16'h0, maxgap = 16'h0, last_gap = 16'h0;
  logic [31:0] rnd = 32'h000163E8;
  logic [15:0] rd_q[$], vec_q[$];
  logic [37:0] wr_q[$];
  int          num_errors = 0, samples_checked = 0;

  qdma_master dut (
    .ref_clk(ref_clk), .reset(reset), .irq_level_sel(irq_level_sel),
    .int_enable(int_enable), .int_event(int_event), .irq_out(irq_out),
    .iak_in(iak_in), .iak_out(iak_out), .din_in(din_in), .sync_in(sync_in),
    .rply_in(rply_in), .rply_out(rply_out), .sync_out(sync_out), .din_out(din_out),
    .dout_out(dout_out), .dmr_out(dmr_out), .dmg_in(dmg_in), .dmg_out(dmg_out),
    .sack_out(sack_out), .other_dmr_in(other_dmr_in), .dal_in(dal_in),
    .dal_out(dal_out), .dal_oe(dal_oe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_addr(cmd_addr), .cmd_words(cmd_words), .cmd_to_mem(cmd_to_mem),
    .cmd_block(cmd_block), .abort(abort), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .busy(busy)
  );

  qdma_host_model host (
    .ref_clk(ref_clk), .reset(reset), .delay(rnd[17:16]), .irq_out(irq_out),
    .rply_out(rply_out), .dmr_out(dmr_out), .sack_out(sack_out), .sync_out(sync_out),
    .din_out(din_out), .dout_out(dout_out), .dal_out(dal_out), .dmg_in(dmg_in),
    .rply_in(rply_in), .iak_in(iak_in), .din_in(din_in), .sync_in(sync_in), .dal_in(dal_in),
    .addr(addr), .addr_cnt(addr_cnt), .mem_wr(mem_wr), .vec_take(vec_take), .seen(seen)
  );

  always #25 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge ref_clk) begin
    rnd <= xs(rnd);
    gap <= (busy && !sack_out) ? gap + 16'h1 : 16'h0;
    if (done) begin
      last_gap <= maxgap;
      maxgap <= 16'h0;
    end else if (gap > maxgap) begin
      maxgap <= gap;
    end
    if (rd_valid) check(rd_data, rd_q.size() ? rd_q.pop_front() : 16'hXXXX);
    if (mem_wr) check({addr, seen}, wr_q.size() ? wr_q.pop_front() : 38'hX);
    if (vec_take) check(seen, vec_q.size() ? vec_q.pop_front() : 16'hXXXX);
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic do_reset(input logic [1:0] lv);
    reset <= 1'b1;
    irq_level_sel <= lv;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(cmd_ready, 1'b1);
  endtask

  task automatic issue(input logic [21:0] a, input logic [15:0] n, input logic m, input logic b);
    for (int i = 0; i < n; i++) begin
      if (!m) rd_q.push_back(16'h5A5A ^ a[15:0] ^ {a[21:16], 10'h000});
      a = a + 22'h000002;
    end
    while (cmd_ready !== 1'b1) @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_addr <= a - {n[14:0], 1'b0};
    cmd_words <= n;
    cmd_to_mem <= m;
    cmd_block <= b;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    check(k < 3000, 1'b1);
    check({sack_out, dmr_out}, 2'h0);
  endtask

  task automatic run(input logic [21:0] a, input logic [15:0] n, input logic m, input logic b,
                     input logic o, input logic [15:0] na, input logic far);
    logic [15:0] a0;
    a0 = addr_cnt;
    other_dmr_in <= o;
    issue(a, n, m, b);
    wait_done();
    repeat (2) @(posedge ref_clk);
    check(addr_cnt - a0, na);
    check(last_gap >= qdma_pkg::PAUSE_CYC, far);
  endtask

  task automatic push_words(input int n);
    for (int i = 0; i < n; i++) begin
      wr_data <= rnd[15:0];
      wr_valid <= 1'b1;
      wr_q.push_back({waddr, rnd[15:0]});
      waddr = waddr + 22'h000002;
      @(posedge ref_clk);
      while (wr_ready !== 1'b1) @(posedge ref_clk);
    end
    wr_valid <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    for (int lv = 0; lv < 4; lv++) begin
      do_reset(lv[1:0]);
      int_enable <= 1'b0;
      int_event <= 1'b1;
      @(posedge ref_clk);
      int_event <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check(irq_out, 4'h0);
      int_enable <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check(irq_out, 4'h0);
      vec_q.push_back(qdma_pkg::VECTOR_DEFAULT);
      int_event <= 1'b1;
      @(posedge ref_clk);
      int_event <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check(irq_out, 4'h1 << lv);
      repeat (20) @(posedge ref_clk);
      check(vec_q.size(), 0);
      check({irq_out, iak_out}, 5'h00);
    end
    run(22'h3FFFF0, 16'd3, 1'b0, 1'b0, 1'b0, 16'd3, 1'b0);
    run(22'h001000, 16'd20, 1'b0, 1'b1, 1'b0, 16'd2, 1'b1);
    run(22'h002000, 16'd20, 1'b0, 1'b1, 1'b1, 16'd3, 1'b0);
    run(22'h002100, 16'd0, 1'b0, 1'b0, 1'b0, 16'd0, 1'b0);
    waddr = 22'h004000;
    push_words(8);
    repeat (2) @(posedge ref_clk);
    check(wr_ready, 1'b0);
    fork
      run(22'h004000, 16'd12, 1'b1, 1'b1, 1'b0, 16'd1, 1'b0);
      push_words(4);
    join
    check(wr_q.size(), 0);
    issue(22'h008000, 16'd40, 1'b0, 1'b1);
    repeat (40) @(posedge ref_clk);
    abort <= 1'b1;
    @(posedge ref_clk);
    abort <= 1'b0;
    wait_done();
    rd_q.delete();
    repeat (5) @(posedge ref_clk);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
